/* gap_timer.sv */
// Millisecond gap timer: counts a requested number of ms, then pulses done
`timescale 1ns/1ps
`default_nettype none
module gap_timer #(
	parameter int CYC_PER_MS = strobe_seq_pkg::CYCLES_PER_MS
) (
	input  wire logic                             i_ref_clk,
	input  wire logic                             i_rst,
	input  wire logic                             i_start,
	input  wire logic [strobe_seq_pkg::GAP_MS_W-1:0] i_ms,
	output logic                                  o_done
);

	localparam logic [strobe_seq_pkg::DIV_W-1:0] DIV_LAST =
		strobe_seq_pkg::DIV_W'(CYC_PER_MS - 1);

	typedef struct packed {
		logic [strobe_seq_pkg::GAP_MS_W-1:0] ms_left;
		logic [strobe_seq_pkg::DIV_W-1:0]    div;
		logic                                busy;
		logic                                done;
	} timer_t;

	timer_t q;
	timer_t d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		if (i_start) begin
			d.ms_left = i_ms;
			d.div = '0;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (q.div == DIV_LAST) begin
				d.div = '0;
				if (q.ms_left <= 7'h01) begin
					d.busy = 1'b0;
					d.done = 1'b1;
				end else begin
					d.ms_left = q.ms_left - 7'h01;
				end
			end else begin
				d.div = q.div + 20'h00001;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_done = q.done;

endmodule // gap_timer
`default_nettype wire

/* seq_props.sv */
// Port assertions for the strobe power sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_props #(
	parameter int CYC_PER_MS = strobe_seq_pkg::CYCLES_PER_MS
) (
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_reg_rd,
	input wire logic       i_seal_broken,
	input wire logic       i_power_up_req,
	input wire logic       i_power_down_req,
	input wire logic       o_reg_rvalid,
	input wire logic       o_first_buck_rail,
	input wire logic       o_second_buck_rail,
	input wire logic       o_third_buck_rail,
	input wire logic       o_buckboost_rail,
	input wire logic [1:0] o_backup_rail,
	input wire logic       o_strobe_pulse,
	input wire logic [3:0] o_strobe_num,
	input wire logic       o_seq_busy,
	input wire logic       o_seq_done
);
	localparam int C = CYC_PER_MS;
	logic      [7:0] gap_q;
	wire logic [5:0] rails = {o_backup_rail, o_buckboost_rail,
		o_third_buck_rail, o_second_buck_rail, o_first_buck_rail};
	// Saturates so a long idle spell cannot wrap into a legal count
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			gap_q <= 8'h00;
		else if (o_strobe_pulse)
			gap_q <= 8'h01;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end
	default clocking dc @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_idle_req;
		!o_seq_busy && (i_power_up_req || i_power_down_req);
	endsequence
	sequence s_walk_open;
		o_seq_busy ##1 o_strobe_pulse;
	endsequence
	AST_RVALID:
		assert property (i_reg_rd |=> o_reg_rvalid) else $error("no answer");
	AST_OPEN:
		assert property (s_idle_req |=> s_walk_open) else $error("no start");
	AST_UP_FIRST:
		assert property (!o_seq_busy && i_power_up_req && !i_seal_broken
			|=> o_strobe_num == 4'h1) else $error("bad first strobe");
	AST_UP_SEALED:
		assert property (!o_seq_busy && i_power_up_req && i_seal_broken
			|=> o_strobe_num == 4'h3) else $error("bad sealed strobe");
	AST_DOWN_FIRST:
		assert property (!o_seq_busy && !i_power_up_req && i_power_down_req
			|=> o_strobe_num == 4'ha) else $error("bad down strobe");
	AST_MIN_GAP:
		assert property (o_strobe_pulse && o_seq_busy |=> !o_strobe_pulse [*8])
			else $error("strobes too close");
	AST_GAP_LEN:
		assert property (o_strobe_pulse && $past(o_seq_busy, 2) |-> int'(gap_q)
			inside {2*C+3, 5*C+3, 20*C+3, 50*C+3}) else $error("bad gap");
	AST_RAILS:
		assert property ($changed(rails) |-> o_strobe_pulse)
			else $error("rail moved off strobe");
	AST_DONE:
		assert property ($fell(o_seq_busy) |-> o_seq_done && o_strobe_pulse)
			else $error("bad end of walk");
endmodule // seq_props
bind strobe_power_sequencer seq_props #(.CYC_PER_MS(CYC_PER_MS)) props_u (
	.i_ref_clk, .i_rst, .i_reg_rd, .i_seal_broken, .i_power_up_req,
	.i_power_down_req, .o_reg_rvalid, .o_first_buck_rail, .o_second_buck_rail,
	.o_third_buck_rail, .o_buckboost_rail, .o_backup_rail, .o_strobe_pulse,
	.o_strobe_num, .o_seq_busy, .o_seq_done);
`default_nettype wire

/* strobe_power_sequencer.sv */
// Strobe power sequencer: configuration registers and up/down strobe walk
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Gaps one to eight: bit 0=2ms, 1=5ms
// - Gap nine chosen by high register bit 0
// - Factor bit set: power-down gaps ten times
// - Power-up gaps never scaled by factor
// - Codes 3h..Ah enable rail at that strobe
// - Other codes leave rail unsequenced
// - Register 0x22 resets to 0x56
// - Register 0x23 resets to 0x45
// - Register 0x20 resets to all zeros
// - Strobes one, two run only while seal unbroken
module strobe_power_sequencer #(
	parameter int CYC_PER_MS = strobe_seq_pkg::CYCLES_PER_MS
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	input  wire logic       i_unlocked,
	input  wire logic       i_seal_broken,
	input  wire logic       i_power_up_req,
	input  wire logic       i_power_down_req,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_rvalid,
	output logic            o_first_buck_rail,
	output logic            o_second_buck_rail,
	output logic            o_third_buck_rail,
	output logic            o_buckboost_rail,
	output logic      [1:0] o_backup_rail,
	output logic            o_strobe_pulse,
	output logic      [3:0] o_strobe_num,
	output logic            o_seq_busy,
	output logic            o_seq_done
);

	typedef struct packed {
		logic [7:0]                 gap_lo;
		logic [7:0]                 gap_hi;
		logic [7:0]                 assign_a;
		logic [7:0]                 assign_b;
		logic [7:0]                 backup;
		strobe_seq_pkg::seq_state_t state;
		logic                       down;
		logic [3:0]                 strobe;
		logic [3:0]                 rails;
		logic [1:0]                 backup_en;
		logic                       t_start;
		logic [6:0]                 t_ms;
		logic                       strobe_pulse;
		logic                       busy;
		logic                       done;
		logic [7:0]                 rdata;
		logic                       rvalid;
	} seq_t;

	seq_t q;
	seq_t d;
	logic timer_done;

	// Rail order in rails: 0 first buck, 1 second, 2 third, 3 buck-boost
	logic [3:0] code [4];
	logic [3:0] gap_num;
	logic       gap_bit;
	logic [6:0] gap_ms;
	logic [3:0] end_strobe;
	logic       last_strobe;
	logic [1:0] bk_code [2];

	always_comb begin
		code[0] = q.assign_a[strobe_seq_pkg::NIB_LO +: 4];
		code[1] = q.assign_a[strobe_seq_pkg::NIB_HI +: 4];
		code[2] = q.assign_b[strobe_seq_pkg::NIB_LO +: 4];
		code[3] = q.assign_b[strobe_seq_pkg::NIB_HI +: 4];
		bk_code[0] = q.backup[strobe_seq_pkg::BACKUP_LO +: 2];
		bk_code[1] = q.backup[strobe_seq_pkg::BACKUP_HI +: 2];
	end

	// Gap n lies between strobe n and n+1; going down from strobe s the
	// gap crossed is the one below it, numbered s-1.
	always_comb begin
		gap_num = q.down ? (q.strobe - 4'h1) : q.strobe;
		if (gap_num <= strobe_seq_pkg::GAPS_IN_LO) begin
			gap_bit = q.gap_lo[3'(gap_num - 4'h1)];
		end else begin
			gap_bit = q.gap_hi[strobe_seq_pkg::HI_GAP9_BIT];
		end
		gap_ms = gap_bit ? strobe_seq_pkg::GAP_LONG_MS
		                 : strobe_seq_pkg::GAP_SHORT_MS;
		// Scaling is applied only on the way down
		if (q.down && q.gap_hi[strobe_seq_pkg::HI_FACTOR_BIT]) begin
			gap_ms = 7'(gap_ms * strobe_seq_pkg::DOWN_FACTOR);
		end
		end_strobe = i_seal_broken ? strobe_seq_pkg::STROBE_SEALED
		                           : strobe_seq_pkg::STROBE_FIRST;
		last_strobe = q.down ? (q.strobe == end_strobe)
		                     : (q.strobe == strobe_seq_pkg::STROBE_LAST);
	end

	always_comb begin
		d = q;
		d.t_start = 1'b0;
		d.strobe_pulse = 1'b0;
		d.done = 1'b0;
		d.rvalid = 1'b0;

		// Configuration writes; a locked port silently drops them
		if (i_reg_wr && i_unlocked) begin
			case (i_reg_addr)
				strobe_seq_pkg::ADDR_GAP_LO: begin
					d.gap_lo = i_reg_wdata;
				end
				strobe_seq_pkg::ADDR_GAP_HI: begin
					d.gap_hi = i_reg_wdata & strobe_seq_pkg::GAP_HI_MASK;
				end
				strobe_seq_pkg::ADDR_ASSIGN_A: begin
					d.assign_a = i_reg_wdata;
				end
				strobe_seq_pkg::ADDR_ASSIGN_B: begin
					d.assign_b = i_reg_wdata;
				end
				strobe_seq_pkg::ADDR_BACKUP: begin
					d.backup = i_reg_wdata & strobe_seq_pkg::BACKUP_MASK;
				end
				default: begin
				end
			endcase
		end

		// Reads answer one cycle later; unmapped offsets read zero
		if (i_reg_rd) begin
			d.rvalid = 1'b1;
			case (i_reg_addr)
				strobe_seq_pkg::ADDR_GAP_LO:   d.rdata = q.gap_lo;
				strobe_seq_pkg::ADDR_GAP_HI:   d.rdata = q.gap_hi;
				strobe_seq_pkg::ADDR_ASSIGN_A: d.rdata = q.assign_a;
				strobe_seq_pkg::ADDR_ASSIGN_B: d.rdata = q.assign_b;
				strobe_seq_pkg::ADDR_BACKUP:   d.rdata = q.backup;
				strobe_seq_pkg::ADDR_STATUS: begin
					d.rdata = {q.busy, q.down, 2'b00, q.strobe};
				end
				default: d.rdata = 8'h00;
			endcase
		end

		case (q.state)
			strobe_seq_pkg::SEQ_IDLE: begin
				// Requests during a walk are ignored, not queued
				if (i_power_up_req) begin
					d.down = 1'b0;
					d.strobe = end_strobe;
					d.busy = 1'b1;
					d.state = strobe_seq_pkg::SEQ_STROBE;
				end else if (i_power_down_req) begin
					d.down = 1'b1;
					d.strobe = strobe_seq_pkg::STROBE_LAST;
					d.busy = 1'b1;
					d.state = strobe_seq_pkg::SEQ_STROBE;
				end
			end
			strobe_seq_pkg::SEQ_STROBE: begin
				d.strobe_pulse = 1'b1;
				for (int r = 0; r < 4; r++) begin
					if (code[r] >= strobe_seq_pkg::CODE_MIN &&
					    code[r] <= strobe_seq_pkg::CODE_MAX &&
					    code[r] == q.strobe) begin
						d.rails[r] = !q.down;
					end
				end
				// Backup rails see strobes one to three (codes 1..3); strobes one and two
				// are never reached once the seal is broken, strobe three always is.
				for (int b = 0; b < 2; b++) begin
					if (bk_code[b] != 2'b00 &&
					    {2'b00, bk_code[b]} == q.strobe) begin
						d.backup_en[b] = !q.down;
					end
				end
				if (last_strobe) begin
					d.busy = 1'b0;
					d.done = 1'b1;
					d.state = strobe_seq_pkg::SEQ_IDLE;
				end else begin
					d.t_start = 1'b1;
					d.t_ms = gap_ms;
					d.state = strobe_seq_pkg::SEQ_GAP;
				end
			end
			strobe_seq_pkg::SEQ_GAP: begin
				if (timer_done) begin
					d.strobe = q.down ? (q.strobe - 4'h1)
					                  : (q.strobe + 4'h1);
					d.state = strobe_seq_pkg::SEQ_STROBE;
				end
			end
			default: begin
				d.state = strobe_seq_pkg::SEQ_IDLE;
				d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q.gap_lo       <= strobe_seq_pkg::RST_GAP_LO;
			q.gap_hi       <= strobe_seq_pkg::RST_GAP_HI;
			q.assign_a     <= strobe_seq_pkg::RST_ASSIGN_A;
			q.assign_b     <= strobe_seq_pkg::RST_ASSIGN_B;
			q.backup       <= strobe_seq_pkg::RST_BACKUP;
			q.state        <= strobe_seq_pkg::SEQ_IDLE;
			q.down         <= 1'b0;
			q.strobe       <= 4'h0;
			q.rails        <= 4'h0;
			q.backup_en    <= 2'b00;
			q.t_start      <= 1'b0;
			q.t_ms         <= 7'h00;
			q.strobe_pulse <= 1'b0;
			q.busy         <= 1'b0;
			q.done         <= 1'b0;
			q.rdata        <= 8'h00;
			q.rvalid       <= 1'b0;
		end else begin
			q <= d;
		end
	end

	gap_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_gap_timer (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_start   (q.t_start),
		.i_ms      (q.t_ms),
		.o_done    (timer_done)
	);

	assign o_reg_rdata        = q.rdata;
	assign o_reg_rvalid       = q.rvalid;
	assign o_first_buck_rail  = q.rails[0];
	assign o_second_buck_rail = q.rails[1];
	assign o_third_buck_rail  = q.rails[2];
	assign o_buckboost_rail   = q.rails[3];
	assign o_backup_rail      = q.backup_en;
	assign o_strobe_pulse     = q.strobe_pulse;
	assign o_strobe_num       = q.strobe;
	assign o_seq_busy         = q.busy;
	assign o_seq_done         = q.done;

endmodule // strobe_power_sequencer
`default_nettype wire

/* strobe_seq_pkg.sv */
// Offsets, reset values, field positions and timing for the strobe sequencer
package strobe_seq_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] ADDR_GAP_LO   = 8'h20;
	localparam logic [7:0] ADDR_GAP_HI   = 8'h21;
	localparam logic [7:0] ADDR_ASSIGN_A = 8'h22;
	localparam logic [7:0] ADDR_ASSIGN_B = 8'h23;
	localparam logic [7:0] ADDR_BACKUP   = 8'h24;
	localparam logic [7:0] ADDR_STATUS   = 8'h2f;

	// Values after reset
	localparam logic [7:0] RST_GAP_LO    = 8'h00;
	localparam logic [7:0] RST_GAP_HI    = 8'h00;
	localparam logic [7:0] RST_ASSIGN_A  = 8'h56;
	localparam logic [7:0] RST_ASSIGN_B  = 8'h45;
	localparam logic [7:0] RST_BACKUP    = 8'h00;

	// Field positions and writable masks
	localparam int         HI_FACTOR_BIT = 7;
	localparam int         HI_GAP9_BIT   = 0;
	localparam logic [7:0] GAP_HI_MASK   = 8'h81;
	localparam logic [7:0] BACKUP_MASK   = 8'h33;
	localparam int         NIB_LO        = 0;
	localparam int         NIB_HI        = 4;
	localparam int         BACKUP_LO     = 0;
	localparam int         BACKUP_HI     = 4;

	// Strobe numbering and assignment code range
	localparam logic [3:0] STROBE_FIRST  = 4'h1;
	localparam logic [3:0] STROBE_SEALED = 4'h3;
	localparam logic [3:0] STROBE_LAST   = 4'ha;
	localparam logic [3:0] CODE_MIN      = 4'h3;
	localparam logic [3:0] CODE_MAX      = 4'ha;
	localparam logic [3:0] GAPS_IN_LO    = 4'h8;

	// Gap durations
	localparam int         GAP_MS_W      = 7;
	localparam logic [6:0] GAP_SHORT_MS  = 7'h02;
	localparam logic [6:0] GAP_LONG_MS   = 7'h05;
	localparam logic [6:0] DOWN_FACTOR   = 7'h0a;

	// Timebase
	localparam int CLK_HZ        = 20_000_000;
	localparam int MS_PER_S      = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
	localparam int DIV_W         = 20;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_STROBE,
		SEQ_GAP
	} seq_state_t;

endpackage

/* testbench.sv */
// Self-checking bench for the strobe power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int C = 4;
	logic       i_ref_clk = 1'b0;
	logic       i_rst = 1'b1;
	logic       i_reg_wr = 1'b0;
	logic       i_reg_rd = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic       i_unlocked = 1'b1;
	logic       i_seal_broken = 1'b0;
	logic       i_power_up_req = 1'b0;
	logic       i_power_down_req = 1'b0;
	logic [7:0] o_reg_rdata;
	logic [3:0] o_strobe_num;
	logic [1:0] o_backup_rail;
	logic       o_reg_rvalid, o_first_buck_rail, o_second_buck_rail;
	logic       o_third_buck_rail, o_buckboost_rail, o_strobe_pulse;
	logic       o_seq_busy, o_seq_done;
	logic [7:0] rg [5];
	logic [5:0] m = 6'h00;
	int         n_errors = 0;
	int         n_compared = 0;
	wire logic [7:0] rails = {2'b00, o_backup_rail, o_buckboost_rail,
		o_third_buck_rail, o_second_buck_rail, o_first_buck_rail};
	// Address, write data, readback after masking
	logic [23:0] rows [8] = '{24'h20a5a5, 24'h21ff81, 24'h223a3a, 24'h232424,
		24'h24ff33, 24'h242121, 24'h2fff00, 24'h30ff00};
	logic [7:0]  rstv [5] = '{8'h00, 8'h00, 8'h56, 8'h45, 8'h00};

	strobe_power_sequencer #(.CYC_PER_MS(C)) dut_u (
		.i_ref_clk          (i_ref_clk),
		.i_rst              (i_rst),
		.i_reg_wr           (i_reg_wr),
		.i_reg_rd           (i_reg_rd),
		.i_reg_addr         (i_reg_addr),
		.i_reg_wdata        (i_reg_wdata),
		.i_unlocked         (i_unlocked),
		.i_seal_broken      (i_seal_broken),
		.i_power_up_req     (i_power_up_req),
		.i_power_down_req   (i_power_down_req),
		.o_reg_rdata        (o_reg_rdata),
		.o_reg_rvalid       (o_reg_rvalid),
		.o_first_buck_rail  (o_first_buck_rail),
		.o_second_buck_rail (o_second_buck_rail),
		.o_third_buck_rail  (o_third_buck_rail),
		.o_buckboost_rail   (o_buckboost_rail),
		.o_backup_rail      (o_backup_rail),
		.o_strobe_pulse     (o_strobe_pulse),
		.o_strobe_num       (o_strobe_num),
		.o_seq_busy         (o_seq_busy),
		.o_seq_done         (o_seq_done)
	);

	always #25 i_ref_clk = ~i_ref_clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_ref_clk);
		i_reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_ref_clk);
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		@(negedge i_ref_clk);
		i_reg_rd = 1'b0;
		chk({7'h00, o_reg_rvalid}, 8'h01);
		chk(o_reg_rdata, e);
	endtask

	// Strobe spacing in cycles after the gap with index g
	function automatic int sp(input logic [3:0] g, input logic dn);
		int ms;
		ms = ((g > 4'h8) ? rg[1][0] : rg[0][g-4'h1]) ? 5 : 2;
		if (dn && rg[1][7])
			ms = ms * 10;
		return ms * C + 3;
	endfunction

	task automatic walk(input logic upw, input logic sl);
		logic [3:0] n;
		logic [3:0] cd [6];
		int         cyc;
		int         last;
		n = upw ? (sl ? 4'h3 : 4'h1) : 4'ha;
		cd = '{rg[2][3:0], rg[2][7:4], rg[3][3:0], rg[3][7:4],
			{2'b00, rg[4][1:0]}, {2'b00, rg[4][5:4]}};
		cyc = 0;
		last = 0;
		i_seal_broken = sl;
		i_power_up_req = upw;
		i_power_down_req = !upw;
		@(negedge i_ref_clk);
		i_power_up_req = 1'b0;
		i_power_down_req = 1'b0;
		for (int k = 0; k < 3000 && o_seq_done !== 1'b1; k++) begin
			@(negedge i_ref_clk);
			cyc++;
			if (o_strobe_pulse === 1'b1) begin
				for (int i = 0; i < 6; i++)
					if (cd[i] == n && (i > 3 || cd[i] > 4'h2))
						m[i] = upw;
				chk({4'h0, o_strobe_num}, {4'h0, n});
				chk(rails, {2'b00, m});
				chk(8'(cyc - last), 8'(last == 0 ? 1 :
					sp(upw ? n - 4'h1 : n, !upw)));
				n = upw ? n + 4'h1 : n - 4'h1;
				last = cyc;
			end
		end
		chk({4'h0, n}, upw ? 8'h0b : (sl ? 8'h02 : 8'h00));
		chk({7'h00, o_seq_done}, 8'h01);
		chk({7'h00, o_seq_busy}, 8'h00);
	endtask

	initial begin
		repeat (20) @(negedge i_ref_clk);
		i_rst = 1'b0;
		foreach (rows[r]) begin
			wr(rows[r][23:16], rows[r][15:8]);
			rd(rows[r][23:16], rows[r][7:0]);
			if (rows[r][23:16] < 8'h25)
				rg[rows[r][18:16]] = rows[r][7:0];
		end
		i_unlocked = 1'b0;
		wr(8'h22, 8'hff);
		i_unlocked = 1'b1;
		rd(8'h22, rg[2]);
		walk(1'b1, 1'b0);
		walk(1'b0, 1'b1);
		walk(1'b1, 1'b1);
		walk(1'b0, 1'b0);
		// Reset in mid-walk must drop rails and restore defaults
		i_power_up_req = 1'b1;
		@(negedge i_ref_clk);
		i_power_up_req = 1'b0;
		repeat (30) @(negedge i_ref_clk);
		chk(rails, 8'h30);
		i_rst = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		chk(rails, 8'h00);
		i_rst = 1'b0;
		foreach (rstv[i])
			rd(8'h20 + 8'(i), rstv[i]);
		print_verdict();
	end

	initial begin
		#1_000_000;
		n_errors++;
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
